/* File: rtl/poeb_top.sv */
/*
 * poeb_top: output-enable bank for eight general-purpose pins, with pin data,
 * write-1-to-clear data, function select and node role, behind an APB slave.
 * Assumes APB inputs synchronous to CLK and pin levels already synchronised.
 */
`timescale 1ns/1ps

// How it works
// RQ1 - eight-bit read/write enable register, bit per pin
// RQ2 - enable one drives pin, zero leaves it off
// RQ3 - enable acts only in general-purpose mode
// RQ4 - bits six to one map shared pins
// RQ5 - main node ignores bit zero for pin drive only; out_en bit 0 is still stored and read back
// RQ6 - only subordinate drives data on pin zero
// RQ7 - driven level from data bit, clear W1C
// RQ8 - all enables zero after reset
module poeb_top (
    input  wire logic                          CLK,
    input  wire logic                          SYS_RST,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [poeb_pkg::ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]                   PWDATA,
    input  wire logic [3:0]                    PSTRB,
    output logic      [31:0]                   PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    input  wire logic [poeb_pkg::PINS-1:0]     ALT_OUT,
    input  wire logic [poeb_pkg::PINS-1:0]     ALT_OE_N,
    input  wire logic [poeb_pkg::PINS-1:0]     PIN_I,
    output logic      [poeb_pkg::PINS-1:0]     PIN_O,
    output logic      [poeb_pkg::PINS-1:0]     PIN_OE_N
);

    poeb_pkg::poeb_state_t s_q;
    poeb_pkg::poeb_state_t s_d;

    logic [poeb_pkg::IDX_W-1:0] idx;
    logic                       aligned;
    logic                       mapped;
    logic                       setup;
    logic                       wr;
    logic [poeb_pkg::PINS-1:0]  gpio_drive;
    logic [poeb_pkg::PINS-1:0]  node_ok;
    logic [31:0]                rd_mux;

    assign idx     = PADDR[poeb_pkg::ADDR_W-1:2];
    assign aligned = (PADDR[1:0] == 2'h0);
    assign setup   = PSEL & ~PENABLE;
    // zero wait states, so every access phase completes
    assign wr      = PSEL & PENABLE & PWRITE & ~s_q.slverr & PSTRB[0];

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (idx)
            poeb_pkg::IDX_OUT_EN:     rd_mux[7:0] = s_q.out_en; // RQ1
            poeb_pkg::IDX_PIN_DATA:   rd_mux[7:0] = s_q.data;
            poeb_pkg::IDX_DATA_CLR:   rd_mux[7:0] = s_q.data;
            poeb_pkg::IDX_PIN_FUNC:   rd_mux[7:0] = s_q.func;
            poeb_pkg::IDX_NODE_CFG:   rd_mux[poeb_pkg::NODE_MAIN_BIT] = s_q.main_node;
            poeb_pkg::IDX_DRIVE_STAT: rd_mux[7:0] = ~PIN_OE_N;
            poeb_pkg::IDX_PIN_LEVEL:  rd_mux[7:0] = PIN_I;
            default:                  mapped = 1'b0;
        endcase
        if (!aligned) begin
            mapped = 1'b0;
            rd_mux = 32'h0000_0000;
        end
    end

    always_comb begin
        s_d = s_q;
        // read data and error are latched in the setup cycle so the
        // access phase presents flop outputs without a wait state
        if (setup) begin
            s_d.rdata  = PWRITE ? 32'h0000_0000 : rd_mux;
            s_d.slverr = ~mapped;
        end
        if (wr) begin
            case (idx)
                poeb_pkg::IDX_OUT_EN:   s_d.out_en = PWDATA[7:0]; // RQ1
                poeb_pkg::IDX_PIN_DATA: s_d.data = PWDATA[7:0];
                poeb_pkg::IDX_DATA_CLR: s_d.data = s_q.data & ~PWDATA[7:0]; // RQ7
                poeb_pkg::IDX_PIN_FUNC: s_d.func = PWDATA[7:0];
                poeb_pkg::IDX_NODE_CFG: s_d.main_node = PWDATA[poeb_pkg::NODE_MAIN_BIT];
                default:                s_d.data = s_q.data;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_q.out_en    <= poeb_pkg::RST_OUT_EN; // RQ8
            s_q.data      <= poeb_pkg::RST_PIN_DATA;
            s_q.func      <= poeb_pkg::RST_PIN_FUNC;
            s_q.main_node <= poeb_pkg::RST_MAIN;
            s_q.rdata     <= 32'h0000_0000;
            s_q.slverr    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA  = s_q.rdata;
    assign PREADY  = 1'b1;
    assign PSLVERR = s_q.slverr;

    // the irq pin's gpio drive is blocked in a main node; other pins ignore the role
    always_comb begin
        node_ok = {poeb_pkg::PINS{1'b1}};
        node_ok[poeb_pkg::PIN_IRQ] = ~s_q.main_node; // RQ5 RQ6
    end

    // func bit 1 hands the pin to its shared function (rx, tx, strap, irq)
    genvar n;
    generate
        for (n = 0; n < poeb_pkg::PINS; n++) begin : g_pin
            assign gpio_drive[n] = s_q.out_en[n] & node_ok[n]; // RQ2 RQ4
            assign PIN_OE_N[n]   = s_q.func[n] ? ALT_OE_N[n] : ~gpio_drive[n]; // RQ3
            assign PIN_O[n]      = s_q.func[n] ? ALT_OUT[n] : s_q.data[n]; // RQ7

            AST_PIN_ON: assert property ( // RQ2
                @(posedge CLK) disable iff (SYS_RST)
                ~s_q.func[n] & s_q.out_en[n] & ((n != 0) | ~s_q.main_node)
                |-> !PIN_OE_N[n])
                else $error("enabled gpio pin not driving");

            AST_PIN_OFF: assert property ( // RQ2
                @(posedge CLK) disable iff (SYS_RST)
                ~s_q.func[n] & ~s_q.out_en[n]
                |-> PIN_OE_N[n])
                else $error("disabled gpio pin driving");

            AST_PIN_ALT: assert property ( // RQ3
                @(posedge CLK) disable iff (SYS_RST)
                s_q.func[n]
                |-> PIN_OE_N[n] == ALT_OE_N[n] && PIN_O[n] == ALT_OUT[n])
                else $error("enable bit reached a function pin");

            AST_PIN_LEVEL: assert property ( // RQ7
                @(posedge CLK) disable iff (SYS_RST)
                ~s_q.func[n]
                |-> PIN_O[n] == s_q.data[n])
                else $error("gpio pin level not from data bit");
        end
    endgenerate

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    logic wr_oen;
    logic wr_clr;
    assign wr_oen = wr & (idx == poeb_pkg::IDX_OUT_EN);
    assign wr_clr = wr & (idx == poeb_pkg::IDX_DATA_CLR);

    AST_OEN_WRITE: assert property ( // RQ1
        wr_oen |=> s_q.out_en == $past(PWDATA[7:0]))
        else $error("enable register did not take written value");

    AST_OEN_READBACK: assert property ( // RQ1
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_OUT_EN)
        |=> PRDATA == {24'h000000, $past(s_q.out_en)} && !PSLVERR)
        else $error("enable register readback wrong");

    AST_DRIVE_ON: assert property ( // RQ2
        wr_oen & (PWDATA[7] == 1'b1) & ~s_q.func[poeb_pkg::PIN_DEDICATED]
        & ~$rose(s_q.func[poeb_pkg::PIN_DEDICATED])
        |=> !PIN_OE_N[poeb_pkg::PIN_DEDICATED] || s_q.func[poeb_pkg::PIN_DEDICATED])
        else $error("enabled pin not driven");

    AST_DRIVE_OFF: assert property ( // RQ2
        (s_q.func == 8'h00) |-> (~PIN_OE_N & ~s_q.out_en) == 8'h00)
        else $error("pin driven without enable");

    AST_ALT_OWNS: assert property ( // RQ3
        s_q.func[poeb_pkg::PIN_RX1]
        |-> PIN_OE_N[poeb_pkg::PIN_RX1] == ALT_OE_N[poeb_pkg::PIN_RX1]
            && PIN_O[poeb_pkg::PIN_RX1] == ALT_OUT[poeb_pkg::PIN_RX1])
        else $error("shared function lost its pin");

    AST_BIT_MAP: assert property ( // RQ4
        ~s_q.func[poeb_pkg::PIN_ADDRESS_STRAP_1_PIN] & s_q.out_en[poeb_pkg::PIN_ADDRESS_STRAP_1_PIN]
        |-> !PIN_OE_N[poeb_pkg::PIN_ADDRESS_STRAP_1_PIN] && PIN_O[poeb_pkg::PIN_ADDRESS_STRAP_1_PIN] == s_q.data[1])
        else $error("bit one does not steer strap-1 pin");

    AST_MAIN_IRQ: assert property ( // RQ5
        s_q.main_node & ~s_q.func[poeb_pkg::PIN_IRQ] |-> PIN_OE_N[poeb_pkg::PIN_IRQ])
        else $error("main node drives irq pin");

    AST_SUB_IRQ: assert property ( // RQ6
        ~s_q.main_node & ~s_q.func[0] & s_q.out_en[0] |-> !PIN_OE_N[0] && PIN_O[0] == s_q.data[0])
        else $error("subordinate irq pin not driving data");

    AST_CLR_W1C: assert property ( // RQ7
        wr_clr |=> s_q.data == ($past(s_q.data) & ~$past(PWDATA[7:0])))
        else $error("write-1-to-clear wrong");

    AST_RST_OFF: assert property ( // RQ8
        $past(SYS_RST) |-> s_q.out_en == 8'h00 && PIN_OE_N == ~(8'h00 | (~ALT_OE_N & s_q.func)))
        else $error("enables not clear after reset");

    AST_PREADY_ZERO_WAIT: assert property ( // RQ1
        PSEL & PENABLE
        |-> PREADY)
        else $error("access phase stalled");

    AST_RDATA_HIGH_ZERO: assert property ( // RQ1
        PSEL & PENABLE & ~PWRITE
        |-> PRDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");

    AST_MISALIGNED: assert property ( // RQ1
        setup & ~aligned
        |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("misaligned access not refused");

    AST_UNMAPPED: assert property ( // RQ1
        setup & aligned & (idx > poeb_pkg::IDX_OUT_EN)
        |=> PSLVERR)
        else $error("unmapped access not refused");

    AST_DATA_READBACK: assert property ( // RQ7
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_PIN_DATA)
        |=> PRDATA[7:0] == $past(s_q.data) && !PSLVERR)
        else $error("data register readback wrong");

    AST_CLR_READBACK: assert property ( // RQ7
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_DATA_CLR)
        |=> PRDATA[7:0] == $past(s_q.data) && !PSLVERR)
        else $error("clear register readback wrong");

    AST_FUNC_READBACK: assert property ( // RQ3
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_PIN_FUNC)
        |=> PRDATA[7:0] == $past(s_q.func) && !PSLVERR)
        else $error("function select readback wrong");

    AST_NODE_READBACK: assert property ( // RQ5
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_NODE_CFG)
        |=> PRDATA[0] == $past(s_q.main_node) && !PSLVERR)
        else $error("node role readback wrong");

    AST_STAT_READBACK: assert property ( // RQ2
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_DRIVE_STAT)
        |=> PRDATA[7:0] == $past(~PIN_OE_N) && !PSLVERR)
        else $error("drive status readback wrong");

    AST_LEVEL_READBACK: assert property ( // RQ3
        setup & ~PWRITE & aligned & (idx == poeb_pkg::IDX_PIN_LEVEL)
        |=> PRDATA[7:0] == $past(PIN_I) && !PSLVERR)
        else $error("pin level readback wrong");

    AST_DATA_WRITE: assert property ( // RQ7
        wr & (idx == poeb_pkg::IDX_PIN_DATA)
        |=> s_q.data == $past(PWDATA[7:0]))
        else $error("data register did not take written value");

    AST_FUNC_WRITE: assert property ( // RQ3
        wr & (idx == poeb_pkg::IDX_PIN_FUNC)
        |=> s_q.func == $past(PWDATA[7:0]))
        else $error("function select did not take written value");

    AST_NODE_WRITE: assert property ( // RQ5
        wr & (idx == poeb_pkg::IDX_NODE_CFG)
        |=> s_q.main_node == $past(PWDATA[poeb_pkg::NODE_MAIN_BIT]))
        else $error("node role did not take written value");

    AST_CLR_ZERO_NOP: assert property ( // RQ7
        wr_clr & (PWDATA[7:0] == 8'h00)
        |=> $stable(s_q.data))
        else $error("clear with zero changed data");

    AST_ERR_NO_WRITE: assert property ( // RQ1
        PSEL & PENABLE & PWRITE & PSLVERR
        |=> $stable(s_q.out_en) && $stable(s_q.data) && $stable(s_q.func))
        else $error("refused write changed state");

    AST_STRB_GATE: assert property ( // RQ1
        PSEL & PENABLE & PWRITE & ~PSTRB[0]
        |=> $stable(s_q.out_en) && $stable(s_q.data) && $stable(s_q.func))
        else $error("write without low strobe changed state");

    AST_OEN_HOLD: assert property ( // RQ1
        ~wr_oen
        |=> $stable(s_q.out_en))
        else $error("enable register changed without a write");

    COV_OEN_WRITE: cover property (wr_oen ##1 (s_q.out_en != 8'h00));
    COV_CLEAR:     cover property (wr_clr ##1 (s_q.data != $past(s_q.data)));
    COV_MAIN_BLOCK: cover property (s_q.main_node & s_q.out_en[0] & ~s_q.func[0]);
    COV_ALT:       cover property (s_q.func != 8'h00);
    COV_ERR:       cover property (PSEL & PENABLE & PSLVERR);

endmodule

/* File: rtl/poeb_pkg.sv */
/*
 * poeb_pkg: register indices, field positions, reset values and the state
 * record of the pin output-enable bank.
 * Assumes a 32-bit APB with 12-bit byte addresses; index = byte address / 4.
 */
package poeb_pkg;

    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned IDX_W    = 10;
    localparam int unsigned PINS     = 8;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PIN_DATA   = 10'h040;
    localparam logic [IDX_W-1:0] IDX_PIN_FUNC   = 10'h041;
    localparam logic [IDX_W-1:0] IDX_NODE_CFG   = 10'h042;
    localparam logic [IDX_W-1:0] IDX_DRIVE_STAT = 10'h043;
    localparam logic [IDX_W-1:0] IDX_PIN_LEVEL  = 10'h044;
    localparam logic [IDX_W-1:0] IDX_DATA_CLR   = 10'h04C;
    localparam logic [IDX_W-1:0] IDX_OUT_EN     = 10'h04D;

    // node configuration field
    localparam int unsigned NODE_MAIN_BIT = 0;

    // pin positions of the shared functions
    localparam int unsigned PIN_DEDICATED = 7;
    localparam int unsigned PIN_RX1       = 6;
    localparam int unsigned PIN_RX0       = 5;
    localparam int unsigned PIN_TX1       = 4;
    localparam int unsigned PIN_TX0       = 3;
    localparam int unsigned PIN_ADDRESS_STRAP_2_PIN      = 2;
    localparam int unsigned PIN_ADDRESS_STRAP_1_PIN      = 1;
    localparam int unsigned PIN_IRQ       = 0;

    // values after reset
    localparam logic [PINS-1:0] RST_OUT_EN   = 8'h00;
    localparam logic [PINS-1:0] RST_PIN_DATA = 8'h00;
    localparam logic [PINS-1:0] RST_PIN_FUNC = 8'h00;
    localparam logic            RST_MAIN     = 1'b0;

    typedef struct packed {
        logic [PINS-1:0] out_en;
        logic [PINS-1:0] data;
        logic [PINS-1:0] func;
        logic            main_node;
        logic [31:0]     rdata;
        logic            slverr;
    } poeb_state_t;

endpackage

/* File: testbench/poeb_top_tb.sv */
/*
 * poeb_top_tb: self-checking bench for the pin output-enable bank, APB master tasks.
 * Assumes the zero-wait APB slave of poeb_top and pins that settle at the edge that completes a write.
 */
`timescale 1ns/1ps
module poeb_top_tb;
    logic        CLK      = 1'b0;
    logic        SYS_RST  = 1'b1;
    logic        PSEL     = 1'b0;
    logic        PENABLE  = 1'b0;
    logic        PWRITE   = 1'b0;
    logic [11:0] PADDR    = 12'h000;
    logic [31:0] PWDATA   = 32'h0;
    logic [3:0]  PSTRB    = 4'hF;
    logic [7:0]  ALT_OUT  = 8'h3C;
    logic [7:0]  ALT_OE_N = 8'hA5;
    logic [7:0]  PIN_I    = 8'h96;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [7:0]  PIN_O;
    logic [7:0]  PIN_OE_N;
    logic [31:0] rd;
    logic        err;
    logic [1:0]  lo       = 2'h0;
    int          fail_count   = 0;
    int          total_checks = 0;

    always #2.5 CLK = ~CLK;

    poeb_top dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .ALT_OUT(ALT_OUT), .ALT_OE_N(ALT_OE_N),
        .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE_N(PIN_OE_N));

    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is seen high at a rising edge, giving up after 50 edges
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= {idx, lo};
        PWDATA  <= {24'h0, wd};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd      = PRDATA;
        err     = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // pins are looked at mid-cycle, well after the committing edge
    task automatic pins(input logic [7:0] oe_n, input logic [7:0] o);
        @(negedge CLK);
        chk("pin_oe_n", {24'h0, PIN_OE_N}, {24'h0, oe_n});
        chk("pin_o", {24'h0, PIN_O}, {24'h0, o});
    endtask

    initial begin
        repeat (5000) @(posedge CLK);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        apb(1'b0, poeb_pkg::IDX_OUT_EN, 8'h00);
        chk("out_en reset", rd, 32'h0);
        pins(8'hFF, 8'h00);
        apb(1'b1, poeb_pkg::IDX_PIN_DATA, 8'h5A);
        apb(1'b1, poeb_pkg::IDX_OUT_EN, 8'hA5);
        apb(1'b0, poeb_pkg::IDX_OUT_EN, 8'h00);
        chk("out_en", rd, 32'h0000_00A5);
        pins(8'h5A, 8'h5A);
        // one pin at a time proves the bit-to-pin map of the shared pins
        for (int n = 1; n <= 6; n++) begin
            apb(1'b1, poeb_pkg::IDX_OUT_EN, 8'h01 << n);
            pins(~(8'h01 << n), 8'h5A);
        end
        apb(1'b1, poeb_pkg::IDX_DATA_CLR, 8'h0F);
        apb(1'b0, poeb_pkg::IDX_PIN_DATA, 8'h00);
        chk("data after clear", rd, 32'h0000_0050);
        apb(1'b1, poeb_pkg::IDX_OUT_EN, 8'hFF);
        apb(1'b1, poeb_pkg::IDX_PIN_FUNC, 8'hF0);
        pins(8'hA0, 8'h30);
        apb(1'b1, poeb_pkg::IDX_PIN_FUNC, 8'h00);
        apb(1'b1, poeb_pkg::IDX_NODE_CFG, 8'h01);
        pins(8'h01, 8'h50);
        apb(1'b0, poeb_pkg::IDX_OUT_EN, 8'h00);
        chk("out_en main", rd, 32'h0000_00FF);
        apb(1'b1, poeb_pkg::IDX_NODE_CFG, 8'h00);
        pins(8'h00, 8'h50);
        chk("no error", {31'h0, err}, 32'h0);
        chk("pready", {31'h0, PREADY}, 32'h1);
        apb(1'b0, poeb_pkg::IDX_NODE_CFG, 8'h00);
        chk("node role", rd, 32'h0);
        apb(1'b0, poeb_pkg::IDX_DRIVE_STAT, 8'h00);
        chk("drive status", rd, 32'h0000_00FF);
        PSTRB <= 4'hE;
        apb(1'b1, poeb_pkg::IDX_OUT_EN, 8'h00);
        PSTRB <= 4'hF;
        apb(1'b0, poeb_pkg::IDX_OUT_EN, 8'h00);
        chk("strobe gate", rd, 32'h0000_00FF);
        apb(1'b1, poeb_pkg::IDX_PIN_FUNC, 8'h81);
        apb(1'b0, poeb_pkg::IDX_PIN_FUNC, 8'h00);
        chk("func readback", rd, 32'h0000_0081);
        pins(8'h81, 8'h50);
        apb(1'b0, poeb_pkg::IDX_DATA_CLR, 8'h00);
        chk("clear readback", rd, 32'h0000_0050);
        lo = 2'h2;
        apb(1'b0, poeb_pkg::IDX_OUT_EN, 8'h00);
        lo = 2'h0;
        chk("misaligned error", {31'h0, err}, 32'h1);
        chk("misaligned data", rd, 32'h0);
        apb(1'b0, poeb_pkg::IDX_PIN_LEVEL, 8'h00);
        chk("pin level", rd, 32'h0000_0096);
        apb(1'b0, 10'h3FF, 8'h00);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wrap_up();
    end
endmodule
